// ==== logic/xmem_pkg.sv ====
// Constants, field layouts and helpers for the memory map decoder.
// Assumes a 50 MHz clock and four clocks per machine cycle.
package xmem_pkg;
  // Register indexes; the byte address is four times the index
  localparam logic [7:0] IDX_CLOCK_CONTROL = 8'h8E;
  localparam logic [7:0] IDX_PROGRAM_MEMORY_LIMIT = 8'hC2;
  localparam logic [7:0] IDX_POWER_MANAGEMENT = 8'hC4;
  localparam logic [7:0] IDX_TIMED_ACCESS = 8'hC7;
  localparam logic [7:0] IDX_BUS_STATUS = 8'h30;
  localparam logic [7:0] RESET_CLOCK_CONTROL = 8'h01;
  localparam logic [7:0] RESET_POWER_MANAGEMENT = 8'h00;
  localparam logic [2:0] RESET_LIMIT = 3'h5;
  localparam logic [2:0] LIMIT_FIRST_RESERVED = 3'h6;
  localparam logic [7:0] TA_KEY_FIRST = 8'hAA;
  localparam logic [7:0] TA_KEY_SECOND = 8'h55;
  localparam logic [3:0] TA_WINDOW = 4'h4;
  localparam logic [15:0] SRAM_TOP = 16'h03FF;
  localparam logic [15:0] LOCK_ADDR = 16'hFFFC;
  localparam int SRAM_DEPTH = 1024;
  localparam logic [5:0] MACHINE_CLOCKS = 6'h04;
  localparam logic [5:0] FETCH_CLOCKS = 6'h04;
  localparam logic [5:0] INTERNAL_MOVE_CLOCKS = 6'h08;
  localparam logic [5:0] MOVE_BASE_CYCLES = 6'h02;
  localparam logic [5:0] STROBE_W0 = 6'h02;
  localparam logic [5:0] STROBE_BEGIN = 6'h01;
  localparam logic [5:0] SETUP_EXTRA = 6'h01;
  localparam logic [5:0] FETCH_STROBE_AT = 6'h02;

  typedef enum logic [1:0] {
    TGT_EXT = 2'h0,
    TGT_SRAM = 2'h1,
    TGT_LOCK = 2'h2,
    TGT_NONE = 2'h3
  } target_t;

  function automatic logic [5:0] strobe_width(input logic [2:0] s);
    return (s == 3'h0) ? STROBE_W0 : {1'b0, s, 2'b00};
  endfunction

  function automatic logic [5:0] setup_extra(input logic [2:0] s);
    return (s == 3'h0) ? 6'h00 : SETUP_EXTRA;
  endfunction

  function automatic logic [5:0] move_clocks(input logic [2:0] s);
    return 6'(({3'h0, s} + MOVE_BASE_CYCLES) * MACHINE_CLOCKS);
  endfunction

  function automatic logic rom_on_chip(input logic [2:0] code, input logic [15:0] a);
    case (code)
      3'h1: return a <= 16'h03FF;
      3'h2: return a <= 16'h07FF;
      3'h3: return a <= 16'h0FFF;
      3'h4: return a <= 16'h1FFF;
      3'h5: return a <= 16'h3FFF;
      default: return 1'b0;
    endcase
  endfunction

  function automatic target_t move_target(input logic [1:0] dme, input logic [15:0] a);
    if (dme == 2'h1 || dme == 2'h3) begin
      if (a <= SRAM_TOP) return TGT_SRAM;
      if (dme == 2'h1) return TGT_EXT;
      return (a == LOCK_ADDR) ? TGT_LOCK : TGT_NONE;
    end
    return TGT_EXT;
  endfunction
endpackage

// ==== logic/sram_if.sv ====
// Port bundle between the decoder and its on-chip data SRAM.
// Assumes a single clock shared by both ends.
interface sram_if;
  logic en;
  logic we;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport host (output en, we, addr, wdata, input rdata);
  modport target (input en, we, addr, wdata, output rdata);
endinterface

// ==== logic/data_sram.sv ====
// The 1KB on-chip data SRAM with registered read data.
// Assumes en is a one-clock pulse per access.
module data_sram (
  input wire logic clock,
  sram_if.target port
);
  import xmem_pkg::*;
  logic [7:0] mem [SRAM_DEPTH];

  always_ff @(posedge clock) begin
    if (port.en && port.we) begin
      mem[port.addr] <= port.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (port.en) begin
      port.rdata <= mem[port.addr];
    end
  end
endmodule // data_sram

// ==== logic/access_counter.sv ====
// Counts the clocks of one bus access of a given length.
// Assumes start comes only while the counter is idle.
module access_counter (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [5:0] length,
  output logic [5:0] count,
  output logic active,
  output logic last
);
  import xmem_pkg::*;
  logic [5:0] span;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count <= 6'h00;
      active <= 1'b0;
      span <= 6'h00;
    end else if (start) begin
      count <= 6'h00;
      active <= 1'b1;
      span <= length;
    end else if (last) begin
      active <= 1'b0;
    end else if (active) begin
      count <= 6'(count + 6'h01);
    end
  end

  assign last = active && (count == 6'(span - 6'h01));
endmodule // access_counter

// ==== logic/memory_map_decode.sv ====
// Program fetch and data move decoder with external bus strobe timing.
// Assumes CPU requests are one-clock pulses taken only while bus_busy is low.
module memory_map_decode (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic [7:0] rom_rdata,
  output logic [13:0] rom_addr,
  output logic fetch_done,
  output logic fetch_off_chip,
  output logic [7:0] fetch_data,
  input wire logic move_req,
  input wire logic move_write,
  input wire logic [15:0] move_addr,
  input wire logic [7:0] move_wdata,
  output logic move_done,
  output logic [7:0] move_rdata,
  output logic bus_busy,
  input wire logic external_access_pin_b,
  input wire logic [2:0] security_lock_states,
  input wire logic [7:0] low_addr_data_port_in,
  output logic [7:0] low_addr_data_port_out,
  output logic low_addr_data_port_oe,
  output logic [7:0] high_addr_port,
  output logic high_addr_port_oe,
  output logic addr_latch_enable,
  output logic program_store_strobe_b,
  output logic read_strobe_b,
  output logic write_strobe_b
);
  import xmem_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_MOVE = 3'b100
  } state_t;

  state_t state;
  target_t target;
  logic [7:0] clock_control;
  logic [7:0] power_management;
  logic [2:0] program_memory_limit;
  logic [1:0] ta_stage;
  logic [3:0] ta_timer;
  logic [15:0] addr;
  logic is_write;
  logic [7:0] wdata;
  logic [5:0] next_length;
  logic [5:0] count;
  logic active;
  logic last;
  logic start;
  logic fetch_ext;
  logic [2:0] stretch;
  logic [5:0] strobe_on;
  logic [5:0] strobe_off;
  logic commit;
  sram_if sram ();

  assign stretch = clock_control[2:0];
  assign commit = avs_write && !avs_waitrequest;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  // Answer one clock after the request is seen, then drop back
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      case (avs_address)
        IDX_CLOCK_CONTROL: avs_readdata <= {24'h000000, clock_control};
        IDX_POWER_MANAGEMENT: avs_readdata <= {24'h000000, power_management};
        IDX_PROGRAM_MEMORY_LIMIT: avs_readdata <= {29'h0, program_memory_limit};
        IDX_BUS_STATUS: avs_readdata <= {28'h0000000, ta_stage, fetch_off_chip, bus_busy};
        default: avs_readdata <= 32'h00000000;
      endcase
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      clock_control <= RESET_CLOCK_CONTROL;
    end else if (commit && avs_address == IDX_CLOCK_CONTROL) begin
      clock_control <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      power_management <= RESET_POWER_MANAGEMENT;
    end else if (commit && avs_address == IDX_POWER_MANAGEMENT) begin
      power_management <= avs_writedata[7:0];
    end
  end

  // Two key writes in a row open a short window for one guarded write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ta_stage <= 2'h0;
      ta_timer <= 4'h0;
    end else if (commit && avs_address == IDX_TIMED_ACCESS) begin
      ta_timer <= TA_WINDOW;
      if (avs_writedata[7:0] == TA_KEY_FIRST) begin
        ta_stage <= 2'h1;
      end else if (avs_writedata[7:0] == TA_KEY_SECOND && ta_stage == 2'h1) begin
        ta_stage <= 2'h2;
      end else begin
        ta_stage <= 2'h0;
      end
    end else if (commit && avs_address == IDX_PROGRAM_MEMORY_LIMIT) begin
      ta_stage <= 2'h0;
    end else if (ta_timer != 4'h0) begin
      ta_timer <= 4'(ta_timer - 4'h1);
    end else begin
      ta_stage <= 2'h0;
    end
  end

  // unlocked writes only
  // Reserved codes are dropped so the decoder never sees them
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      program_memory_limit <= RESET_LIMIT;
    end else if (commit && avs_address == IDX_PROGRAM_MEMORY_LIMIT && ta_stage == 2'h2
                 && avs_writedata[2:0] < LIMIT_FIRST_RESERVED) begin
      program_memory_limit <= avs_writedata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencing

  // Moves win over fetches when both arrive together
  assign start = (state == ST_IDLE) && (fetch_req || move_req);
  always_comb begin
    if (move_req) begin
      next_length = (move_target(power_management[1:0], move_addr) == TGT_EXT)
                    ? move_clocks(stretch) : INTERNAL_MOVE_CLOCKS;
    end else begin
      next_length = FETCH_CLOCKS;
    end
  end

  access_counter timer (
    .clock(clock),
    .rst_b(rst_b),
    .start(start),
    .length(next_length),
    .count(count),
    .active(active),
    .last(last)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      target <= TGT_EXT;
      addr <= 16'h0000;
      is_write <= 1'b0;
      wdata <= 8'h00;
      fetch_ext <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (move_req) begin
            state <= ST_MOVE;
            addr <= move_addr;
            is_write <= move_write;
            wdata <= move_wdata;
            target <= move_target(power_management[1:0], move_addr);
          end else if (fetch_req) begin
            state <= ST_FETCH;
            addr <= fetch_addr;
            is_write <= 1'b0;
            fetch_ext <= !external_access_pin_b
                         || !rom_on_chip(program_memory_limit, fetch_addr);
          end
        end
        ST_FETCH, ST_MOVE: begin
          if (last) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal targets

  assign sram.en = (state == ST_MOVE) && (target == TGT_SRAM) && active && (count == 6'h00);
  assign sram.we = is_write;
  assign sram.addr = addr[9:0];
  assign sram.wdata = wdata;

  data_sram ram (
    .clock(clock),
    .port(sram.target)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rom_addr <= 14'h0000;
    end else if (start) begin
      rom_addr <= fetch_addr[13:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answers to the CPU

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fetch_done <= 1'b0;
      move_done <= 1'b0;
      fetch_off_chip <= 1'b0;
      fetch_data <= 8'h00;
      move_rdata <= 8'h00;
      bus_busy <= 1'b0;
    end else begin
      fetch_done <= (state == ST_FETCH) && last;
      move_done <= (state == ST_MOVE) && last;
      bus_busy <= !(state != ST_IDLE && last) && (start || state != ST_IDLE);
      if (state == ST_FETCH && last) begin
        fetch_off_chip <= fetch_ext;
        fetch_data <= fetch_ext ? low_addr_data_port_in : rom_rdata;
      end
      if (state == ST_MOVE && !is_write) begin
        if (target == TGT_EXT && active && count == 6'(strobe_off - 6'h01)) begin
          move_rdata <= low_addr_data_port_in;
        end else if (last) begin
          case (target)
            TGT_SRAM: move_rdata <= sram.rdata;
            TGT_LOCK: move_rdata <= {5'h00, security_lock_states};
            TGT_NONE: move_rdata <= 8'h00;
            default: move_rdata <= move_rdata;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External bus pins

  // Pins are decoded from the count and shown one clock later
  // setup and hold stretch
  assign strobe_on = 6'(STROBE_BEGIN + setup_extra(stretch));
  assign strobe_off = 6'(strobe_on + strobe_width(stretch));

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      addr_latch_enable <= 1'b0;
      program_store_strobe_b <= 1'b1;
      read_strobe_b <= 1'b1;
      write_strobe_b <= 1'b1;
      low_addr_data_port_out <= 8'h00;
      low_addr_data_port_oe <= 1'b0;
      high_addr_port <= 8'h00;
      high_addr_port_oe <= 1'b0;
    end else begin
      addr_latch_enable <= 1'b0;
      program_store_strobe_b <= 1'b1;
      read_strobe_b <= 1'b1;
      write_strobe_b <= 1'b1;
      low_addr_data_port_oe <= 1'b0;
      high_addr_port_oe <= 1'b0;
      if (active && !last && ((state == ST_FETCH && fetch_ext)
          || (state == ST_MOVE && target == TGT_EXT))) begin
        high_addr_port <= addr[15:8];
        high_addr_port_oe <= 1'b1;
        if (count == 6'h00) begin
          addr_latch_enable <= 1'b1;
          low_addr_data_port_out <= addr[7:0];
          low_addr_data_port_oe <= 1'b1;
        end else if (state == ST_FETCH) begin
          program_store_strobe_b <= !(count == FETCH_STROBE_AT);
        end else begin
          // Count 0 carries the address latch, so the strobe window starts after it
          if (count >= strobe_on && count < strobe_off) begin
            read_strobe_b <= is_write;
            write_strobe_b <= !is_write;
          end
          if (is_write && count < 6'(strobe_off + setup_extra(stretch))) begin
            low_addr_data_port_out <= wdata;
            low_addr_data_port_oe <= 1'b1;
          end
        end
      end
    end
  end
endmodule // memory_map_decode

// ==== verification/memory_map_decode_asserts.sv ====
// Checker for register handshake, fetch timing and external strobes.
// Sees only top-level ports of the decoder; bound below.
module memory_map_decode_asserts (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic fetch_req,
  input wire logic fetch_done,
  input wire logic move_req,
  input wire logic move_done,
  input wire logic bus_busy,
  input wire logic low_addr_data_port_oe,
  input wire logic high_addr_port_oe,
  input wire logic addr_latch_enable,
  input wire logic program_store_strobe_b,
  input wire logic read_strobe_b,
  input wire logic write_strobe_b
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [5:0] low_n;
  ////////////////////////////////////////
  // Counts strobe low time, since widths reach 28 clocks
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      low_n <= 6'h00;
    end else if (!read_strobe_b || !write_strobe_b) begin
      low_n <= low_n + 6'h01;
    end else begin
      low_n <= 6'h00;
    end
  end
  ////////////////////////////////////////
  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no register answer");
  property p_wait_once;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("wait low too long");
  property p_fetch_time;
    fetch_req && !bus_busy && !move_req |-> ##1 !fetch_done [*4] ##1 fetch_done;
  endproperty
  a_fetch_time: assert property (p_fetch_time) else $error("fetch length wrong");
  property p_move_bound;
    move_req && !bus_busy |-> ##[9:37] move_done;
  endproperty
  a_move_bound: assert property (p_move_bound) else $error("move too long");
  property p_program_store_strobe_one;
    $fell(program_store_strobe_b) |=> program_store_strobe_b;
  endproperty
  a_program_store_strobe_one: assert property (p_program_store_strobe_one) else $error("fetch strobe width");
  property p_program_store_strobe_bus;
    !program_store_strobe_b |-> high_addr_port_oe && !low_addr_data_port_oe
      && read_strobe_b && write_strobe_b;
  endproperty
  a_program_store_strobe_bus: assert property (p_program_store_strobe_bus) else $error("fetch strobe off bus");
  property p_strobe_bus;
    !read_strobe_b || !write_strobe_b |-> high_addr_port_oe && bus_busy
      && (read_strobe_b || write_strobe_b);
  endproperty
  a_strobe_bus: assert property (p_strobe_bus) else $error("strobe off bus");
  property p_strobe_width;
    low_n != 6'h00 && read_strobe_b && write_strobe_b |->
      low_n == 6'h02 || (low_n[1:0] == 2'h0 && low_n >= 6'h04 && low_n <= 6'h1C);
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("strobe width");
  property p_ale_one;
    addr_latch_enable |=> !addr_latch_enable;
  endproperty
  a_ale_one: assert property (p_ale_one) else $error("address latch width");
  c_fetch: cover property (fetch_done);
  c_move: cover property (move_done);
  c_long: cover property (low_n == 6'h1C);
endmodule // memory_map_decode_asserts

bind memory_map_decode memory_map_decode_asserts i_memory_map_decode_asserts (
  .clock, .rst_b, .avs_read, .avs_write, .avs_waitrequest, .fetch_req, .fetch_done,
  .move_req, .move_done, .bus_busy, .low_addr_data_port_oe, .high_addr_port_oe,
  .addr_latch_enable, .program_store_strobe_b, .read_strobe_b, .write_strobe_b);

// ==== verification/ext_mem_model.sv ====
// Behavioural external memory on the multiplexed port pair.
// Assumes registered active-low strobes; 256 data bytes, code folds in the high byte.
module ext_mem_model (
  input wire logic clock,
  input wire logic [7:0] low_addr_data_port_out,
  input wire logic low_addr_data_port_oe,
  input wire logic [7:0] high_addr_port,
  input wire logic addr_latch_enable,
  input wire logic program_store_strobe_b,
  input wire logic read_strobe_b,
  input wire logic write_strobe_b,
  output logic [7:0] low_addr_data_port_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] addr = 16'h0000;
  logic [7:0] mem [256] = '{default: 8'h00};
  logic [7:0] idle = 8'h00;
  ////////////////////////////////////////
  // address latch
  always @(posedge clock) begin
    if (addr_latch_enable) addr <= {high_addr_port, low_addr_data_port_out};
    if (!write_strobe_b && low_addr_data_port_oe) mem[addr[7:0]] <= low_addr_data_port_out;
    idle <= ~low_addr_data_port_in;
  end
  // code on strobe
  // Released bus toggles every clock so a stale byte never reads as valid
  assign low_addr_data_port_in = !program_store_strobe_b ? ~(addr[7:0] ^ addr[15:8]) :
    !read_strobe_b ? mem[addr[7:0]] : idle;
endmodule // ext_mem_model

// ==== verification/test_memory_map_decode.sv ====
// Self-checking bench for the memory map decoder.
// Assumes the external memory model and checker bind are compiled first.
module test_memory_map_decode;
  timeunit 1ns;
  timeprecision 1ns;
  import xmem_pkg::*;
  logic clock, rst_b, avs_read, avs_write, avs_waitrequest, fetch_req, fetch_done;
  logic fetch_off_chip, move_req, move_write, move_done, bus_busy, external_access_pin_b;
  logic low_addr_data_port_oe, high_addr_port_oe, addr_latch_enable;
  logic program_store_strobe_b, read_strobe_b, write_strobe_b;
  logic [7:0] avs_address, rom_rdata, fetch_data, move_wdata, move_rdata;
  logic [7:0] low_addr_data_port_in, low_addr_data_port_out, high_addr_port;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] fetch_addr, move_addr;
  logic [13:0] rom_addr;
  logic [2:0] security_lock_states;
  int mismatches, n_tests, n_cyc, n_program_store_strobe, n_rd, n_wr;
  memory_map_decode i_memory_map_decode (.clock, .rst_b, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .fetch_req, .fetch_addr, .rom_rdata,
    .rom_addr, .fetch_done, .fetch_off_chip, .fetch_data, .move_req, .move_write, .move_addr,
    .move_wdata, .move_done, .move_rdata, .bus_busy, .external_access_pin_b,
    .security_lock_states, .low_addr_data_port_in, .low_addr_data_port_out,
    .low_addr_data_port_oe, .high_addr_port, .high_addr_port_oe, .addr_latch_enable,
    .program_store_strobe_b, .read_strobe_b, .write_strobe_b);
  ext_mem_model i_ext_mem_model (.clock, .low_addr_data_port_out, .low_addr_data_port_oe,
    .high_addr_port, .addr_latch_enable, .program_store_strobe_b, .read_strobe_b,
    .write_strobe_b, .low_addr_data_port_in);
  // On-chip ROM stand-in
  assign rom_rdata = rom_addr[7:0] ^ 8'h5A;
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  ////////////////////////////////////////
  task automatic conclude;
    if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic hang;
    mismatches++;
    conclude();
  endtask
  task automatic reg_acc(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    @(posedge clock);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= idx;
    avs_writedata <= {24'h000000, wd};
    for (k = 0; k < 20; k++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 20) hang();
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic set_limit(input logic [7:0] code);
    reg_acc(1'b1, IDX_TIMED_ACCESS, TA_KEY_FIRST);
    reg_acc(1'b1, IDX_TIMED_ACCESS, TA_KEY_SECOND);
    reg_acc(1'b1, IDX_PROGRAM_MEMORY_LIMIT, code);
  endtask
  // One fetch or move; counts clocks and strobe-low clocks up to done
  task automatic xfer(input logic mv, input logic w, input logic [15:0] a,
    input logic [7:0] wd);
    int k;
    @(posedge clock);
    if (mv) begin
      move_req <= 1'b1;
      move_write <= w;
      move_addr <= a;
      move_wdata <= wd;
    end else begin
      fetch_req <= 1'b1;
      fetch_addr <= a;
    end
    @(posedge clock);
    move_req <= 1'b0;
    fetch_req <= 1'b0;
    n_cyc = 0;
    n_program_store_strobe = 0;
    n_rd = 0;
    n_wr = 0;
    for (k = 0; k < 60; k++) begin
      @(posedge clock);
      n_cyc++;
      n_program_store_strobe += !program_store_strobe_b;
      n_rd += !read_strobe_b;
      n_wr += !write_strobe_b;
      if (move_done === 1'b1 || fetch_done === 1'b1) break;
    end
    if (k == 60) hang();
    rd = {24'h000000, mv ? move_rdata : fetch_data};
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    chk({program_store_strobe_b, read_strobe_b, write_strobe_b}, 3'h7);
    reg_acc(1'b0, IDX_CLOCK_CONTROL, 8'h00);
    chk(rd, 32'h01);
    reg_acc(1'b0, IDX_POWER_MANAGEMENT, 8'h00);
    chk(rd, 32'h00);
    reg_acc(1'b0, IDX_PROGRAM_MEMORY_LIMIT, 8'h00);
    chk(rd, 32'h05);
    reg_acc(1'b1, 8'h10, 8'hFF);
    reg_acc(1'b0, 8'h10, 8'h00);
    chk(rd, 32'h00);
  endtask
  task automatic t_limits;
    logic [15:0] lim [6] = '{16'h0000, 16'h03FF, 16'h07FF, 16'h0FFF, 16'h1FFF, 16'h3FFF};
    logic [15:0] a;
    for (int c = 0; c < 6; c++) begin
      set_limit(8'(c));
      reg_acc(1'b0, IDX_PROGRAM_MEMORY_LIMIT, 8'h00);
      chk(rd, 32'(c));
      xfer(1'b0, 1'b0, lim[c], 8'h00);
      chk({fetch_off_chip, n_program_store_strobe[3:0], rd[7:0]}, (c == 0) ? {5'h11, ~lim[c][7:0]} :
        {5'h00, lim[c][7:0] ^ 8'h5A});
      a = lim[c] + 16'h0001;
      xfer(1'b0, 1'b0, a, 8'h00);
      chk({fetch_off_chip, n_program_store_strobe[3:0], rd[7:0]}, {5'h11, ~(a[7:0] ^ a[15:8])});
    end
    reg_acc(1'b1, IDX_PROGRAM_MEMORY_LIMIT, 8'h01);
    reg_acc(1'b0, IDX_PROGRAM_MEMORY_LIMIT, 8'h00);
    chk(rd, 32'h05);
    set_limit(8'h06);
    reg_acc(1'b0, IDX_PROGRAM_MEMORY_LIMIT, 8'h00);
    chk(rd, 32'h05);
  endtask
  task automatic t_stretch;
    for (int s = 0; s < 8; s++) begin
      reg_acc(1'b1, IDX_CLOCK_CONTROL, 8'(s));
      xfer(1'b1, 1'b1, 16'h1230 + 16'(s), 8'hA0 + 8'(s));
      chk(n_cyc, (s + 2) * 4 + 1);
      chk(n_wr, (s == 0) ? 2 : 4 * s);
      xfer(1'b1, 1'b0, 16'h1230 + 16'(s), 8'h00);
      chk(n_rd, (s == 0) ? 2 : 4 * s);
      chk(rd, 32'hA0 + 32'(s));
    end
    external_access_pin_b <= 1'b0;
    xfer(1'b0, 1'b0, 16'h0100, 8'h00);
    chk({fetch_off_chip, n_program_store_strobe[3:0], rd[7:0]}, 13'h11FE);
    chk(n_cyc, 5);
    external_access_pin_b <= 1'b1;
  endtask
  task automatic t_data;
    reg_acc(1'b1, IDX_CLOCK_CONTROL, 8'h01);
    xfer(1'b1, 1'b1, 16'h03FF, 8'hE1);
    chk(n_wr, 4);
    reg_acc(1'b1, IDX_POWER_MANAGEMENT, 8'h01);
    xfer(1'b1, 1'b1, 16'h03FF, 8'h3C);
    chk(n_cyc, 9);
    chk(n_wr, 0);
    xfer(1'b1, 1'b0, 16'h03FF, 8'h00);
    chk({n_rd[7:0], rd[7:0]}, 16'h003C);
    xfer(1'b1, 1'b1, 16'h0400, 8'h77);
    xfer(1'b1, 1'b0, 16'h0400, 8'h00);
    chk({n_rd[7:0], rd[7:0]}, 16'h0477);
    reg_acc(1'b1, IDX_POWER_MANAGEMENT, 8'h03);
    xfer(1'b1, 1'b0, LOCK_ADDR, 8'h00);
    chk({n_rd[7:0], rd[7:0]}, 16'h0005);
    xfer(1'b1, 1'b1, 16'h0500, 8'h99);
    chk(n_wr, 0);
    xfer(1'b1, 1'b0, 16'h03FF, 8'h00);
    chk(rd, 32'h3C);
    reg_acc(1'b1, IDX_POWER_MANAGEMENT, 8'h00);
    xfer(1'b1, 1'b0, 16'h03FF, 8'h00);
    chk({n_rd[7:0], rd[7:0]}, 16'h04E1);
  endtask
  ////////////////////////////////////////
  initial begin
    {rst_b, avs_read, avs_write, fetch_req, move_req, move_write} = 6'h00;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    {fetch_addr, move_addr, move_wdata} = 40'h0000000000;
    external_access_pin_b = 1'b1;
    security_lock_states = 3'h5;
    mismatches = 0;
    n_tests = 0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    t_limits();
    t_stretch();
    t_data();
    // Second reset mid-run must restore defaults
    reg_acc(1'b1, IDX_CLOCK_CONTROL, 8'h06);
    rst_b <= 1'b0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    conclude();
  end
endmodule // test_memory_map_decode
